// ### sfr_host_model.sv
`timescale 1ns/1ps
module sfr_host_model (
    input  wire logic clk,
    output logic      restart_n,
    output logic      select_n,
    output logic      sclk
);
    initial begin
        restart_n = 1'b1;
        select_n  = 1'b1;
        sclk      = 1'b0;
    end
    //////////////////////////////////////////////////////////////////////
    task automatic set_restart(input logic v);
        @(negedge clk) restart_n = v;
    endtask
    // hold high 100 ns after release before anything else
    task automatic restart_pulse(input int cyc);
        @(negedge clk) restart_n = 1'b0;
        repeat (cyc) @(negedge clk);
        restart_n = 1'b1;
        repeat (20) @(negedge clk);
    endtask
    // 48 ns serial clock: below every per-command limit
    task automatic open_frame(input int bits);
        @(negedge clk) select_n = 1'b0;
        repeat (bits) begin
            #24 sclk = 1'b1;
            #24 sclk = 1'b0;
        end
    endtask
    task automatic close_frame();
        @(negedge clk) select_n = 1'b1;
        repeat (10) @(negedge clk);
    endtask
endmodule

// ### sfr_pkg.sv
package sfr_pkg;

    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned CLK_PERIOD_PS    = 5000;

    // power-up wait in microseconds (plain default)
    localparam int unsigned POWER_UP_WAIT_US = 300;
    localparam int unsigned POWER_UP_CYC     = POWER_UP_WAIT_US * CLK_MHZ;

    // restart completion, least time, microseconds
    localparam int unsigned RESTART_COMPLETION_TIME_US = 35;
    localparam int unsigned RESTART_COMPLETION_CYC     =
        RESTART_COMPLETION_TIME_US * CLK_MHZ;

    // restart pulse width, least time, ns
    localparam int unsigned RESTART_PULSE_WIDTH_NS = 200;
    localparam int unsigned RESTART_PULSE_CYC      =
        (RESTART_PULSE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int unsigned CNT_W = 17;

    typedef enum logic [2:0] {
        SFR_POR,
        SFR_READY,
        SFR_PULSE,
        SFR_WARM,
        SFR_HELD
    } sfr_state_e;

endpackage

// ### sfr_seq.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - select low while ready means device selected and in active power
// - after deselect stay active until pending operations end, then standby
// - power-on initialisation lasts the power-up wait after supply good
// - restart input ignored during power-on initialisation
// - restart falling edge reinitialises state over completion time
// - failed power-on makes restart run full power-up instead
// - restart low 200 ns aborts work, floats outputs, ignores commands
// - restart low at power-up end keeps device in reset
module sfr_seq #(
    parameter int unsigned POWER_UP_CYC = sfr_pkg::POWER_UP_CYC,
    parameter int unsigned COMPLETE_CYC = sfr_pkg::RESTART_COMPLETION_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic supply_good,
    input  wire logic por_fault,
    input  wire logic restart_n,
    input  wire logic select_n,
    input  wire logic sclk,
    input  wire logic op_busy,
    output logic      ready,
    output logic      active_power,
    output logic      standby,
    output logic      outputs_float,
    output logic      abort_op,
    output logic      cmd_accept,
    output logic      regs_init
);
    //////////////////////////////////////////////////////////////////////////
    sfr_sync_if sy ();

    sfr_sync u_sync (
        .clk           (clk),
        .rst           (rst),
        .restart_n_pin (restart_n),
        .select_n_pin  (select_n),
        .sclk_pin      (sclk),
        .sy            (sy)
    );

    //////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        sfr_pkg::sfr_state_e       st;
        logic [sfr_pkg::CNT_W-1:0] cnt;
        logic [7:0]                pw;
        logic                      rn_prev;
        logic                      por_ok;
        logic                      ready;
        logic                      active;
        logic                      standby;
        logic                      float_o;
        logic                      abort;
        logic                      accept;
        logic                      init;
    } sfr_seq_s;

    sfr_seq_s q;
    sfr_seq_s d;

    logic fall;
    assign fall = q.rn_prev & ~sy.restart_n;

    always_comb begin
        d         = q;
        d.rn_prev = sy.restart_n;
        d.abort   = 1'b0;
        d.init    = 1'b0;
        case (q.st)
            sfr_pkg::SFR_POR: begin
                // restart pin only looked at once the power-up wait ends
                if (!supply_good) begin
                    d.cnt = '0;
                end else if (q.cnt >= sfr_pkg::CNT_W'(POWER_UP_CYC - 1)) begin
                    d.por_ok = ~por_fault;
                    d.init   = 1'b1;
                    d.cnt    = '0;
                    // still low at the end: stay in reset until it rises
                    d.st     = sy.restart_n ? sfr_pkg::SFR_READY
                                            : sfr_pkg::SFR_HELD;
                end else begin
                    d.cnt = q.cnt + 1'b1;
                end
            end
            sfr_pkg::SFR_HELD: begin
                if (sy.restart_n) begin
                    d.st = sfr_pkg::SFR_READY;
                end
            end
            sfr_pkg::SFR_READY: begin
                if (fall) begin
                    d.pw  = '0;
                    d.cnt = '0;
                    d.st  = sfr_pkg::SFR_PULSE;
                end
            end
            sfr_pkg::SFR_PULSE: begin
                // glitches shorter than the least pulse do nothing
                if (sy.restart_n) begin
                    d.st = sfr_pkg::SFR_READY;
                end else if (q.pw >= 8'(sfr_pkg::RESTART_PULSE_CYC - 1)) begin
                    d.abort = 1'b1;
                    d.init  = 1'b1;
                    d.cnt   = sfr_pkg::CNT_W'(q.pw) + 1'b1;
                    d.st    = q.por_ok ? sfr_pkg::SFR_WARM
                                       : sfr_pkg::SFR_POR;
                    if (!q.por_ok) begin
                        d.cnt = '0;
                    end
                end else begin
                    d.pw = q.pw + 1'b1;
                end
            end
            sfr_pkg::SFR_WARM: begin
                // counted from the falling edge, on our own clock
                if (q.cnt >= sfr_pkg::CNT_W'(COMPLETE_CYC - 1)) begin
                    d.st = sy.restart_n ? sfr_pkg::SFR_READY
                                        : sfr_pkg::SFR_HELD;
                end else begin
                    d.cnt = q.cnt + 1'b1;
                end
            end
            default: d.st = sfr_pkg::SFR_POR;
        endcase
        d.ready   = (d.st == sfr_pkg::SFR_READY) ||
                    (d.st == sfr_pkg::SFR_PULSE);
        d.float_o = ~d.ready;
        d.accept  = d.ready & ~sy.select_n;
        // pending work keeps power up after deselect
        d.active  = d.ready & (~sy.select_n | op_busy);
        d.standby = d.ready & ~d.active;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '{st: sfr_pkg::SFR_POR, rn_prev: 1'b1, float_o: 1'b1,
                   default: '0};
        end else begin
            q <= d;
        end
    end

    assign ready         = q.ready;
    assign active_power  = q.active;
    assign standby       = q.standby;
    assign outputs_float = q.float_o;
    assign abort_op      = q.abort;
    assign cmd_accept    = q.accept;
    assign regs_init     = q.init;

    //////////////////////////////////////////////////////////////////////////
    sequence s_long_low;
        (q.st == sfr_pkg::SFR_PULSE && !sy.restart_n) [*8];
    endsequence

    // a long restart may start while selected; abort legally drops power
    a_active_select: assert property (@(posedge clk) disable iff (rst)
        (q.ready && !sy.select_n && !d.abort) |=> active_power)
        else $error("selected but not active");
    a_busy_hold: assert property (@(posedge clk) disable iff (rst)
        (q.ready && op_busy && sy.select_n) |=> !standby)
        else $error("standby while busy");
    a_por_ignore: assert property (@(posedge clk) disable iff (rst)
        (q.st == sfr_pkg::SFR_POR && q.cnt != '0 && supply_good)
        |=> (q.st == sfr_pkg::SFR_POR || q.st == sfr_pkg::SFR_READY ||
             q.st == sfr_pkg::SFR_HELD))
        else $error("restart acted during power-up");
    a_pulse_abort: assert property (@(posedge clk) disable iff (rst)
        s_long_low ##0 (q.por_ok && q.pw == 8'(sfr_pkg::RESTART_PULSE_CYC-1))
        |=> abort_op && q.st == sfr_pkg::SFR_WARM)
        else $error("long restart did not abort");
    a_float_reset: assert property (@(posedge clk) disable iff (rst)
        (q.st == sfr_pkg::SFR_WARM) |-> outputs_float && !cmd_accept)
        else $error("outputs driven during restart");
    a_por_fault: assert property (@(posedge clk) disable iff (rst)
        (q.st == sfr_pkg::SFR_PULSE && !q.por_ok && d.abort)
        |=> q.st == sfr_pkg::SFR_POR)
        else $error("faulty power-up not rerun");
    a_held_low: assert property (@(posedge clk) disable iff (rst)
        (q.st == sfr_pkg::SFR_HELD && !sy.restart_n)
        |=> q.st == sfr_pkg::SFR_HELD && !ready)
        else $error("left reset while restart low");
    a_warm_time: assert property (@(posedge clk) disable iff (rst)
        $rose(q.st == sfr_pkg::SFR_WARM) |-> !ready [*8])
        else $error("warm restart too short");
endmodule

// ### sfr_seq_bench.sv
`timescale 1ns/1ps
module sfr_seq_bench;
    localparam int PU = 200;
    localparam int CP = 60;
    logic clk = 0;
    logic rst, supply_good, por_fault, op_busy;
    logic restart_n, select_n, sclk, ready, active_power, standby;
    logic outputs_float, abort_op, cmd_accept, regs_init;
    int   fails = 0, checks_done = 0, n_abort = 0, n_init = 0, k;
    always #2.5 clk = ~clk;
    sfr_host_model host (.clk(clk), .restart_n(restart_n),
        .select_n(select_n), .sclk(sclk));
    sfr_seq #(.POWER_UP_CYC(PU), .COMPLETE_CYC(CP)) DUT (.clk(clk),
        .rst(rst), .supply_good(supply_good), .por_fault(por_fault),
        .restart_n(restart_n), .select_n(select_n), .sclk(sclk),
        .op_busy(op_busy), .ready(ready), .active_power(active_power),
        .standby(standby), .outputs_float(outputs_float),
        .abort_op(abort_op), .cmd_accept(cmd_accept),
        .regs_init(regs_init));
    // count on the falling edge, where the pulses have settled
    always @(negedge clk) begin
        if (abort_op === 1'b1) n_abort++;
        if (regs_init === 1'b1) n_init++;
    end
    //////////////////////////////////////////////////////////////////////
    task automatic check(input logic got, input logic exp, input string m);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    // ready must rise between lo and hi cycles from now
    task automatic wait_ready(input int lo, input int hi);
        for (k = 0; k <= hi && ready !== 1'b1; k++) @(negedge clk);
        check(k >= lo && k <= hi, 1'b1, "ready time");
    endtask
    task automatic cold(input logic fault);
        por_fault = fault;
        supply_good = 1'b0;
        rst = 1'b1;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        supply_good = 1'b1;
        n_abort = 0;
        n_init = 0;
    endtask
    task automatic end_of_test();
        $display("checks %0d, fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    //////////////////////////////////////////////////////////////////////
    task automatic t_power_up();
        cold(1'b0);
        fork host.restart_pulse(45); join_none
        wait_ready(PU - 5, PU + 15);
        @(negedge clk);
        // only the power-up init pulse itself, nothing from the restart
        check(n_abort == 0 && n_init == 1, 1'b1, "restart in init");
        check(outputs_float, 1'b0, "float after init");
        check(standby, 1'b1, "standby after init");
    endtask
    task automatic t_activity();
        host.open_frame(8);
        repeat (4) @(negedge clk);
        check(active_power, 1'b1, "active on select");
        check(cmd_accept, 1'b1, "accept on select");
        check(standby, 1'b0, "standby on select");
        op_busy = 1'b1;
        host.close_frame();
        check(active_power, 1'b1, "active while busy");
        check(standby, 1'b0, "standby while busy");
        op_busy = 1'b0;
        repeat (4) @(negedge clk);
        check(standby, 1'b1, "standby after busy");
        check(active_power, 1'b0, "active after busy");
    endtask
    task automatic t_short();
        host.restart_pulse(30);
        check(n_abort == 0 && ready === 1'b1, 1'b1, "short pulse");
    endtask
    task automatic t_warm();
        n_abort = 0;
        n_init = 0;
        op_busy = 1'b1;
        fork host.restart_pulse(45); join_none
        repeat (50) @(negedge clk);
        check(n_abort == 1 && n_init == 1, 1'b1, "abort pulses");
        check(outputs_float, 1'b1, "float in restart");
        check(ready, 1'b0, "ready in restart");
        op_busy = 1'b0;
        wait_ready(CP - 55, CP - 35);
        check(outputs_float, 1'b0, "float after restart");
    endtask
    task automatic t_held();
        host.set_restart(1'b0);
        cold(1'b0);
        repeat (PU + 40) @(negedge clk);
        check(ready, 1'b0, "held ready");
        check(outputs_float, 1'b1, "held float");
        host.set_restart(1'b1);
        wait_ready(0, CP + 10);
        repeat (20) @(negedge clk);
    endtask
    task automatic t_fault();
        cold(1'b1);
        repeat (PU + 30) @(negedge clk);
        por_fault = 1'b0;
        fork host.restart_pulse(45); join_none
        repeat (50) @(negedge clk);
        wait_ready(PU - 60, PU + 20);
    endtask
    initial begin
        op_busy = 1'b0;
        t_power_up();
        t_activity();
        t_short();
        t_warm();
        t_held();
        t_fault();
        end_of_test();
    end
    // whole run needs about 1250 cycles
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        end_of_test();
    end
endmodule

// ### sfr_sync.sv
`timescale 1ns/1ps
module sfr_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic restart_n_pin,
    input  wire logic select_n_pin,
    input  wire logic sclk_pin,
    sfr_sync_if.src   sy
);
    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
    } sfr_sync_s;

    sfr_sync_s st_q;
    sfr_sync_s st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = {restart_n_pin, select_n_pin, sclk_pin};
        st_d.s2 = st_q.s1;
    end

    // restart and select pins idle high, sclk idles low; all three reset high
    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '{s1: 3'h7, s2: 3'h7};
        end else begin
            st_q <= st_d;
        end
    end

    assign sy.restart_n = st_q.s2[2];
    assign sy.select_n  = st_q.s2[1];
    assign sy.sclk      = st_q.s2[0];
endmodule

// ### sfr_sync_if.sv
`timescale 1ns/1ps
interface sfr_sync_if;
    logic restart_n;
    logic select_n;
    logic sclk;
    modport src (output restart_n, output select_n, output sclk);
    modport dst (input restart_n, input select_n, input sclk);
endinterface
